// >>> shared/switchgear_pkg.sv
// Package with constants and types for the switchgear position and command control block
package switchgear_pkg;

    // Breaker state codes
    localparam logic [1:0] STATE_INDETERM = 2'h0;
    localparam logic [1:0] STATE_OPEN = 2'h1;
    localparam logic [1:0] STATE_CLOSED = 2'h2;
    localparam logic [1:0] STATE_DISTURBED = 2'h3;

    // Command source permission encodings
    localparam logic [1:0] PERM_NONE = 2'h0;
    localparam logic [1:0] PERM_LOCAL = 2'h1;
    localparam logic [1:0] PERM_REMOTE = 2'h2;
    localparam logic [1:0] PERM_BOTH = 2'h3;

    // Widths of timers, trip slots and interlocks
    localparam int TIMER_W = 16;
    localparam int TRIP_SLOTS = 8;
    localparam int NUM_ILOCK = 3;

    // Reset values
    localparam logic [TIMER_W-1:0] TIMER_RESET = 16'h0000;
    localparam logic [1:0] SYNC_RESET = 2'h0;

    // Reload values that software supplies as ports
    typedef struct packed {
        logic [TIMER_W-1:0] close_travel;   // Close travel time in ticks
        logic [TIMER_W-1:0] open_travel;    // Open travel time in ticks
        logic [TIMER_W-1:0] settle;         // Settle delay, zero means none
        logic [TIMER_W-1:0] trip_hold;      // Minimum trip hold in ticks
        logic [TIMER_W-1:0] sync_wait;      // Synchronism wait limit in ticks
    } timing_cfg_t;

    // Wiring and mode configuration
    typedef struct packed {
        logic closed_contact_wired;         // Closed-position contact assigned
        logic open_contact_wired;           // Open-position contact assigned
        logic trip_latched;                 // Latched trip mode
        logic sync_assigned;                // Synchronism source assigned
        logic [1:0] permission;             // Command source permission
    } mode_cfg_t;

    // Position indication outputs
    typedef struct packed {
        logic closed;                       // Position closed
        logic open;                         // Position open
        logic in_transit;                   // Position in transit
        logic fault;                        // Position fault
        logic [1:0] code;                   // Breaker state code
    } position_t;

    // Motion sequence states
    typedef enum logic [5:0] {
        MOV_IDLE = 6'b000001,
        MOV_SYNC = 6'b000010,
        MOV_CLOSE = 6'b000100,
        MOV_OPEN = 6'b001000,
        MOV_SETTLE = 6'b010000,
        MOV_FAIL = 6'b100000
    } motion_t;

endpackage : switchgear_pkg

// >>> design/switchgear_control.sv
// Switchgear position supervision, trip combiner and command control
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Close starts travel timer, report transit
// - Closed contact in time sets closed, ok
// - Close timer expiry with zero settle reports position fault
// - Settle delay after close keeps transit
// - Code 0 moving, 1 open, 2 closed
// - Unassigned closed and open contacts give code 3
// - Open starts open timer, confirm gives ok
// - Open timer expiry with zero settle reports position fault
// - Settle delay after open keeps transit
// - Unassigned open and closed contacts give code 3
// - Three interlocks block each direction
// - Protection and reclose bypass interlocks
// - OR of assigned trip slots
// - Only combined trip reaches breaker
// - Trip held minimum time, latch selectable
// - Latched trip stays until acknowledged or no slot assigned
// - Latch clears after sources drop, on ack
// - One external close, one external open
// - Close on edge, open on level, priority
// - Remote commands need remote permission
// - Close waits for sync within limit
// - No sync source means always released
// - State code two bits, four values
// - Command output ends on confirm, timeout
// - Single contact raises one_contact_flag
module switchgear_control (
    input wire logic ref_clk,                                   // System clock, 20 MHz
    input wire logic reset_n,                                   // Asynchronous reset, active low
    input wire logic clk_en,                                    // Clock enable, freezes state when low
    input wire switchgear_pkg::timing_cfg_t timing,             // Timer reload values
    input wire switchgear_pkg::mode_cfg_t mode,                 // Wiring and mode settings
    input wire logic aux_closed,                                // Closed-position contact
    input wire logic aux_open,                                  // Open-position contact
    input wire logic [switchgear_pkg::TRIP_SLOTS-1:0] trip_source,      // Protection trip sources
    input wire logic [switchgear_pkg::TRIP_SLOTS-1:0] trip_source_slot, // Slot assignment mask
    input wire logic trip_ack,                                  // Operator or remote acknowledge
    input wire logic trip_clear_input,                          // Assigned trip acknowledge signal
    input wire logic reclose_request,                           // Reclose from auto_reclose_unit
    input wire logic protection_block,                          // Separate block of protection open
    input wire logic [switchgear_pkg::NUM_ILOCK-1:0] close_interlock, // Close interlocks
    input wire logic [switchgear_pkg::NUM_ILOCK-1:0] open_interlock,  // Open interlocks
    input wire logic ext_close_request,                         // External close, edge active
    input wire logic ext_open_request,                          // External open, level active
    input wire logic local_close,                               // Local panel close pulse
    input wire logic local_open,                                // Local panel open pulse
    input wire logic remote_close,                              // Remote system close pulse
    input wire logic remote_open,                               // Remote system open pulse
    input wire logic phase_match_release,                       // Synchronism signal
    output logic close_cmd,                                     // Close command relay
    output logic open_cmd,                                      // Open command relay
    output logic trip_out,                                      // Combined trip command
    output switchgear_pkg::position_t position,                 // Position indication
    output logic switch_done_ok,                                // Switching success pulse
    output logic one_contact_flag,                              // Single-contact supervision
    output logic sync_timeout                                   // Close dropped, no synchronism
);

    // Registered inputs
    logic s_closed;                          // Sampled closed contact
    logic s_open;                            // Sampled open contact
    logic s_ext_close;                       // Sampled external close
    logic s_ext_close_d;                     // Previous external close
    logic s_ext_open;                        // Sampled external open
    logic [switchgear_pkg::TRIP_SLOTS-1:0] s_trip; // Sampled trip sources

    // Motion state
    switchgear_pkg::motion_t state;          // Current motion state
    switchgear_pkg::motion_t next_state;     // Next motion state
    logic [switchgear_pkg::TIMER_W-1:0] timer;      // Motion timer
    logic [switchgear_pkg::TIMER_W-1:0] next_timer; // Next motion timer
    logic last_dir_close;                    // Direction of last movement
    logic next_last_dir_close;               // Next direction
    logic fault;                             // Fault indication
    logic next_fault;                        // Next fault
    logic done_ok;                           // Success pulse register
    logic next_done_ok;                      // Next success pulse
    logic sync_to;                           // Sync timeout pulse
    logic next_sync_to;                      // Next sync timeout

    // Trip combiner state
    logic trip;                              // Trip output register
    logic next_trip;                         // Next trip
    logic [switchgear_pkg::TIMER_W-1:0] hold;       // Trip hold counter
    logic [switchgear_pkg::TIMER_W-1:0] next_hold;  // Next hold counter

    // Position outputs
    switchgear_pkg::position_t next_position; // Next position indication

    // Command decode
    logic trip_any;                          // Any assigned source active
    logic remote_ok;                         // Remote commands allowed
    logic local_ok;                          // Local commands allowed
    logic req_close;                         // Interlock-checked close request
    logic req_open;                          // Interlock-checked open request
    logic close_ilock;                       // Any close interlock active
    logic open_ilock;                        // Any open interlock active
    logic confirm_closed;                    // Closed end position seen
    logic confirm_open;                      // Open end position seen

    // Input sampling register
    // contact, external request and trip inputs registered first; local, remote and interlock inputs are not
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_closed <= 1'b0;
            s_open <= 1'b0;
            s_ext_close <= 1'b0;
            s_ext_close_d <= 1'b0;
            s_ext_open <= 1'b0;
            s_trip <= '0;
        end else if (clk_en) begin
            s_closed <= aux_closed;
            s_open <= aux_open;
            s_ext_close <= ext_close_request;
            s_ext_close_d <= s_ext_close;
            s_ext_open <= ext_open_request;
            s_trip <= trip_source;
        end
    end

    // Command qualification
    always_comb begin
        trip_any = |(s_trip & trip_source_slot);
        remote_ok = (mode.permission == switchgear_pkg::PERM_REMOTE) ||
                    (mode.permission == switchgear_pkg::PERM_BOTH);
        local_ok = (mode.permission == switchgear_pkg::PERM_LOCAL) ||
                   (mode.permission == switchgear_pkg::PERM_BOTH);
        close_ilock = |close_interlock;
        open_ilock = |open_interlock;
        // open level wins over close edge
        req_open = !open_ilock && ((remote_ok && (remote_open || s_ext_open)) || (local_ok && local_open));
        req_close = !close_ilock && !req_open &&
                    ((remote_ok && (remote_close || (s_ext_close && !s_ext_close_d))) ||
                     (local_ok && local_close));
        confirm_closed = mode.closed_contact_wired ? s_closed : (mode.open_contact_wired && !s_open);
        confirm_open = mode.open_contact_wired ? s_open : (mode.closed_contact_wired && !s_closed);
    end

    // Trip combiner next values
    always_comb begin
        next_trip = trip;
        next_hold = (hold != switchgear_pkg::TIMER_RESET) ? hold - 1'b1 : hold;
        if (trip_any) begin
            next_trip = 1'b1;
            next_hold = timing.trip_hold;
        end else if (trip && (hold == switchgear_pkg::TIMER_RESET)) begin
            if (!mode.trip_latched || trip_ack || trip_clear_input || (trip_source_slot == '0)) begin
                next_trip = 1'b0;
            end
        end
    end

    // Trip combiner register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            trip <= 1'b0;
            hold <= switchgear_pkg::TIMER_RESET;
        end else if (clk_en) begin
            trip <= next_trip;
            hold <= next_hold;
        end
    end

    // Motion sequence next values
    always_comb begin
        next_state = state;
        next_timer = (timer != switchgear_pkg::TIMER_RESET) ? timer - 1'b1 : timer;
        next_last_dir_close = last_dir_close;
        next_fault = fault;
        next_done_ok = 1'b0;
        next_sync_to = 1'b0;
        case (state)
            switchgear_pkg::MOV_IDLE: begin
                // protection trip and reclose bypass interlocks
                if (trip && !protection_block && !confirm_open) begin
                    next_state = switchgear_pkg::MOV_OPEN;
                    next_timer = timing.open_travel;
                    next_last_dir_close = 1'b0;
                    next_fault = 1'b0;
                end else if (req_open && !confirm_open) begin
                    next_state = switchgear_pkg::MOV_OPEN;
                    next_timer = timing.open_travel;
                    next_last_dir_close = 1'b0;
                    next_fault = 1'b0;
                end else if ((req_close || reclose_request) && !confirm_closed) begin
                    next_last_dir_close = 1'b1;
                    next_fault = 1'b0;
                    if (mode.sync_assigned && !phase_match_release) begin
                        next_state = switchgear_pkg::MOV_SYNC;
                        next_timer = timing.sync_wait;
                    end else begin
                        next_state = switchgear_pkg::MOV_CLOSE;
                        next_timer = timing.close_travel;
                    end
                end
            end
            switchgear_pkg::MOV_SYNC: begin
                if (phase_match_release) begin
                    next_state = switchgear_pkg::MOV_CLOSE;
                    next_timer = timing.close_travel;
                end else if (timer == switchgear_pkg::TIMER_RESET) begin
                    next_state = switchgear_pkg::MOV_IDLE;
                    next_sync_to = 1'b1;
                end
            end
            switchgear_pkg::MOV_CLOSE, switchgear_pkg::MOV_OPEN: begin
                if (last_dir_close ? confirm_closed : confirm_open) begin
                    next_state = switchgear_pkg::MOV_IDLE;
                    next_done_ok = 1'b1;
                end else if (timer == switchgear_pkg::TIMER_RESET) begin
                    if (timing.settle != switchgear_pkg::TIMER_RESET) begin
                        next_state = switchgear_pkg::MOV_SETTLE;
                        next_timer = timing.settle;
                    end else begin
                        next_state = switchgear_pkg::MOV_FAIL;
                        next_fault = 1'b1;
                    end
                end
            end
            switchgear_pkg::MOV_SETTLE: begin
                if (timer == switchgear_pkg::TIMER_RESET) begin
                    next_state = switchgear_pkg::MOV_IDLE;
                end
            end
            switchgear_pkg::MOV_FAIL: begin
                next_state = switchgear_pkg::MOV_IDLE;
            end
            default: begin
                next_state = switchgear_pkg::MOV_IDLE;
            end
        endcase
    end

    // Position indication next values
    always_comb begin
        next_position.closed = 1'b0;
        next_position.open = 1'b0;
        next_position.fault = next_fault;
        // transit while travel or settle runs
        next_position.in_transit = (next_state == switchgear_pkg::MOV_CLOSE) ||
                                   (next_state == switchgear_pkg::MOV_OPEN) ||
                                   (next_state == switchgear_pkg::MOV_SETTLE);
        next_position.code = switchgear_pkg::STATE_INDETERM;
        if (!mode.closed_contact_wired && !mode.open_contact_wired) begin
            next_position.code = switchgear_pkg::STATE_DISTURBED;
        end else if (next_position.in_transit) begin
            next_position.code = switchgear_pkg::STATE_INDETERM;
        end else if (next_fault) begin
            next_position.code = switchgear_pkg::STATE_DISTURBED;
        end else if (confirm_closed) begin
            next_position.closed = 1'b1;
            next_position.code = switchgear_pkg::STATE_CLOSED;
        end else begin
            next_position.open = 1'b1;
            next_position.code = switchgear_pkg::STATE_OPEN;
        end
    end

    // Motion and position register
    // no command asserted after reset
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= switchgear_pkg::MOV_IDLE;
            timer <= switchgear_pkg::TIMER_RESET;
            last_dir_close <= 1'b0;
            fault <= 1'b0;
            done_ok <= 1'b0;
            sync_to <= 1'b0;
            position <= '0;
        end else if (clk_en) begin
            state <= next_state;
            timer <= next_timer;
            last_dir_close <= next_last_dir_close;
            fault <= next_fault;
            done_ok <= next_done_ok;
            sync_to <= next_sync_to;
            position <= next_position;
        end
    end

    // Output drive
    always_comb begin
        // command lasts travel time plus one cycle at most
        close_cmd = (state == switchgear_pkg::MOV_CLOSE);
        open_cmd = (state == switchgear_pkg::MOV_OPEN);
        trip_out = trip;
        switch_done_ok = done_ok;
        sync_timeout = sync_to;
        one_contact_flag = mode.closed_contact_wired ^ mode.open_contact_wired;
    end

endmodule : switchgear_control

`default_nettype wire

// >>> verif/switchgear_monitor.sv
// Checker watching the switchgear control block ports
`timescale 1ns/100ps
`default_nettype none
module switchgear_monitor (
    input wire logic ref_clk, // System clock
    input wire logic reset_n, // Reset, active low
    input wire logic clk_en, // Clock enable
    input wire switchgear_pkg::timing_cfg_t timing, // Timer reloads
    input wire switchgear_pkg::mode_cfg_t mode, // Wiring and mode
    input wire logic [switchgear_pkg::TRIP_SLOTS-1:0] trip_source, // Trip sources
    input wire logic [switchgear_pkg::TRIP_SLOTS-1:0] trip_source_slot, // Slot mask
    input wire logic close_cmd, // Close relay
    input wire logic open_cmd, // Open relay
    input wire logic trip_out, // Combined trip
    input wire switchgear_pkg::position_t position, // Position indication
    input wire logic switch_done_ok, // Success pulse
    input wire logic one_contact_flag, // Single-contact flag
    input wire logic sync_timeout // Synchronism wait expired
);
    logic [15:0] close_run; // Cycles the close relay has stood
    // Counts how long the close relay stays energised
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            close_run <= 16'h0000;
        end else if (clk_en) begin
            close_run <= close_cmd ? close_run + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_reset_quiet: assert property (disable iff (1'h0) !reset_n |-> !close_cmd && !open_cmd && !trip_out)
        else $error("command active during reset");
    a_cmd_bounded: assert property (close_run <= timing.close_travel + 16'h0001)
        else $error("close command outlasts travel time");
    a_cmd_transit: assert property (close_cmd || open_cmd |-> position.in_transit)
        else $error("command without transit indication");
    a_transit_code: assert property (position.in_transit |-> position.code == switchgear_pkg::STATE_INDETERM)
        else $error("transit with wrong state code");
    a_closed_code: assert property (position.closed |-> position.code == switchgear_pkg::STATE_CLOSED)
        else $error("closed with wrong state code");
    a_open_code: assert property (position.open |-> position.code == switchgear_pkg::STATE_OPEN)
        else $error("open with wrong state code");
    a_fault_code: assert property (position.fault |-> position.code == switchgear_pkg::STATE_DISTURBED && !position.in_transit)
        else $error("fault with wrong state code");
    a_done_pulse: assert property (switch_done_ok |-> (position.closed || position.open) ##1 !switch_done_ok)
        else $error("success pulse malformed");
    a_one_contact: assert property (one_contact_flag == (mode.closed_contact_wired ^ mode.open_contact_wired))
        else $error("single-contact flag wrong");
    a_trip_follows: assert property (clk_en && |(trip_source & trip_source_slot) |-> ##[1:2] trip_out)
        else $error("assigned trip not passed on");
    a_trip_assigned: assert property ($rose(trip_out) |-> |trip_source_slot)
        else $error("trip without assigned slot");
    a_sync_only: assert property (sync_timeout |-> mode.sync_assigned && !close_cmd)
        else $error("synchronism timeout without source");
    c_close_ok: cover property (switch_done_ok && position.closed);
    c_fault: cover property (position.fault);
    c_sync_timeout: cover property (sync_timeout);
endmodule : switchgear_monitor
`default_nettype wire

// >>> verif/breaker_model.sv
// Behavioural breaker with auxiliary contacts and command coils
`timescale 1ns/100ps
`default_nettype none
module breaker_model #(parameter int DELAY = 2) (
    input wire logic ref_clk, // System clock
    input wire logic reset_n, // Reset, active low
    input wire logic close_cmd, // Close coil
    input wire logic open_cmd, // Open coil
    input wire logic stuck, // Jammed mechanism, never moves
    output logic aux_closed, // Closed-position contact
    output logic aux_open // Open-position contact
);
    int run; // Cycles the active coil has pulled
    logic shut; // Main contacts closed
    // Contacts move only after the coil pulls for DELAY cycles
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            run <= 0;
            shut <= 1'h0;
        end else if (stuck || !(close_cmd || open_cmd)) begin
            run <= 0;
        end else if (run < DELAY) begin
            run <= run + 1;
        end else begin
            shut <= close_cmd;
        end
    end
    assign aux_closed = shut;
    assign aux_open = !shut;
endmodule : breaker_model
`default_nettype wire

// >>> verif/tb.sv
// Testbench for the switchgear control block
`timescale 1ns/100ps
`default_nettype none
bind switchgear_control switchgear_monitor mon (.ref_clk, .reset_n, .clk_en, .timing, .mode, .trip_source,
    .trip_source_slot, .close_cmd, .open_cmd, .trip_out, .position, .switch_done_ok, .one_contact_flag, .sync_timeout);
module tb;
    logic ref_clk, reset_n, clk_en, aux_closed, aux_open, trip_ack, trip_clear_input, reclose_request; // Controls
    logic protection_block, ext_close_request, ext_open_request, local_close, local_open; // Requests
    logic remote_close, remote_open, phase_match_release, stuck; // Requests and model control
    logic close_cmd, open_cmd, trip_out, switch_done_ok, one_contact_flag, sync_timeout; // Outputs
    logic [switchgear_pkg::TRIP_SLOTS-1:0] trip_source, trip_source_slot; // Trip inputs
    logic [switchgear_pkg::NUM_ILOCK-1:0] close_interlock, open_interlock; // Interlocks
    switchgear_pkg::timing_cfg_t timing; // Timer reloads
    switchgear_pkg::mode_cfg_t mode; // Wiring and mode
    switchgear_pkg::position_t position; // Position indication
    int n_fail = 0; // Mismatches
    int checked = 0; // Comparisons
    switchgear_control dut (.ref_clk, .reset_n, .clk_en, .timing, .mode, .aux_closed, .aux_open, .trip_source,
        .trip_source_slot, .trip_ack, .trip_clear_input, .reclose_request, .protection_block, .close_interlock,
        .open_interlock, .ext_close_request, .ext_open_request, .local_close, .local_open, .remote_close,
        .remote_open, .phase_match_release, .close_cmd, .open_cmd, .trip_out, .position, .switch_done_ok,
        .one_contact_flag, .sync_timeout);
    breaker_model bm (.ref_clk, .reset_n, .close_cmd, .open_cmd, .stuck, .aux_closed, .aux_open);
    initial ref_clk = 1'h0;
    // Clock at 20 MHz
    always #25 ref_clk = ~ref_clk;
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    task automatic conclude();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Selects an output to wait on
    function automatic logic pick(input int k);
        case (k)
            0: return close_cmd;
            1: return open_cmd;
            2: return switch_done_ok;
            default: return sync_timeout;
        endcase
    endfunction : pick
    // Bounded wait; running out counts as a mismatch
    task automatic await(input int k);
        int n;
        n = 0;
        while (pick(k) !== 1'h1 && n < 40) begin
            n++;
            cyc(1);
        end
        if (n == 40) begin
            check(16'h0000, 16'h0001);
            conclude();
        end
    endtask : await
    initial begin
        int n;
        {trip_ack, trip_clear_input, reclose_request, protection_block, ext_close_request} = '0;
        reset_n = 1'h1;
        {ext_open_request, local_close, local_open, remote_close, remote_open, phase_match_release, stuck} = '0;
        {trip_source, trip_source_slot, close_interlock, open_interlock} = '0;
        clk_en = 1'h1;
        timing = '{16'h0008, 16'h0008, 16'h0000, 16'h0004, 16'h0006};
        mode = '{1'h1, 1'h0, 1'h1, 1'h0, switchgear_pkg::PERM_REMOTE};
        // Reset falls after time zero so every flop sees the edge
        #1 reset_n = 1'h0;
        cyc(3);
        reset_n = 1'h1;
        check(16'(one_contact_flag), 16'h0001);
        for (int i = 0; i < 3; i++) begin
            close_interlock = 3'h1 << i;
            remote_close = 1'h1;
            cyc(1);
            remote_close = 1'h0;
            cyc(5);
            check(16'(close_cmd), 16'h0000);
        end
        close_interlock = 3'h7;
        reclose_request = 1'h1;
        cyc(1);
        reclose_request = 1'h0;
        await(0);
        check(16'({position.in_transit, position.code}), 16'h0004);
        await(2);
        check(16'({position.closed, position.code}), 16'h0006);
        close_interlock = 3'h0;
        $display("interlock and close test done");
        mode.permission = switchgear_pkg::PERM_LOCAL;
        remote_open = 1'h1;
        cyc(1);
        remote_open = 1'h0;
        cyc(5);
        check(16'(open_cmd), 16'h0000);
        mode.permission = switchgear_pkg::PERM_REMOTE;
        open_interlock = 3'h7;
        trip_source_slot = 8'h04;
        trip_source = 8'h01;
        cyc(5);
        check(16'(trip_out), 16'h0000);
        trip_source = 8'h05;
        await(1);
        trip_source = 8'h00;
        await(2);
        check(16'({position.open, position.code}), 16'h0005);
        cyc(10);
        check(16'(trip_out), 16'h0001);
        trip_ack = 1'h1;
        cyc(3);
        check(16'(trip_out), 16'h0000);
        trip_ack = 1'h0;
        trip_source = 8'h04;
        cyc(3);
        trip_source = 8'h00;
        cyc(8);
        check(16'(trip_out), 16'h0001);
        trip_clear_input = 1'h1;
        cyc(3);
        check(16'(trip_out), 16'h0000);
        {trip_clear_input, open_interlock} = '0;
        $display("trip test done");
        mode.sync_assigned = 1'h1;
        ext_close_request = 1'h1;
        cyc(3);
        ext_close_request = 1'h0;
        await(3);
        check(16'(position.closed), 16'h0000);
        phase_match_release = 1'h1;
        remote_close = 1'h1;
        cyc(1);
        remote_close = 1'h0;
        await(0);
        await(2);
        mode = '{1'h0, 1'h1, 1'h1, 1'h0, switchgear_pkg::PERM_REMOTE};
        ext_open_request = 1'h1;
        await(1);
        await(2);
        check(16'({position.open, position.code}), 16'h0005);
        ext_open_request = 1'h0;
        $display("synchronism and external test done");
        mode.closed_contact_wired = 1'h1;
        mode.open_contact_wired = 1'h0;
        stuck = 1'h1;
        for (int s = 0; s < 2; s++) begin
            timing.settle = s ? 16'h0003 : 16'h0000;
            // Let the failed state return to idle first
            cyc(1);
            remote_close = 1'h1;
            cyc(1);
            remote_close = 1'h0;
            await(0);
            n = 0;
            while (close_cmd === 1'h1 && n < 40) begin
                n++;
                cyc(1);
            end
            check(16'(n), timing.close_travel + 16'h0001);
            if (s == 0) begin
                check(16'({position.fault, position.in_transit, position.code}), 16'h000b);
            end else begin
                check(16'({position.in_transit, position.code}), 16'h0004);
                cyc(5);
                check(16'(position.in_transit), 16'h0000);
            end
        end
        $display("travel expiry test done");
        mode.closed_contact_wired = 1'h0;
        cyc(3);
        check(16'(position.code), 16'h0003);
        $display("unwired test done");
        conclude();
    end
endmodule : tb
`default_nettype wire
